// ---- sim/irc_cfg_bank_sva.sv ----
// Port checker for the IR config bank
`timescale 1ns/1ns
module irc_cfg_bank_sva (
   // Clock, reset and config access
   input wire logic CLK, NRST, CFG_STATE,
   input wire logic [7:0] CFG_INDEX, CFG_RDATA,
   input wire irc_pkg::irc_io_t CFG_IO,
   // Runtime decode
   input wire logic [15:0] IO_ADDR,
   input wire logic RT_SEL, RT_WAKE_SEL,
   input wire logic [4:0] RT_OFFSET,
   // Engine side and DMA pins
   input wire irc_pkg::irc_eng_wr_t ENG_WR,
   input wire logic ENG_SOFT_RST, ENG_DMA_REQ,
   input wire logic [7:0] ENG_TMO, ENG_SW_SEL_A,
   input wire logic [3:0] DMA_REQUEST_OUT_O, DMA_REQUEST_OUT_OE
);
   import irc_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   wire cw = CFG_STATE && CFG_IO.wr;
   wire cr = CFG_STATE && CFG_IO.rd;
   wire ew = ENG_WR.wr && ENG_WR.blk == IRC_ENG_BLK_TMO && ENG_WR.addr == IRC_ENG_ADR_TMO;
   a_cfg_gate: assert property (!CFG_STATE && !ew |=> $stable(CFG_RDATA) && $stable(ENG_TMO))
      else $error("access outside config state took effect");
   a_dma_select: assert property (cw && CFG_INDEX == IRC_IDX_DMA_SEL |=> DMA_REQUEST_OUT_OE ==
      ($past(CFG_IO.data[3:0]) <= IRC_DMA_MAX ? 4'h1 << $past(CFG_IO.data[3:0]) : 4'h0))
      else $error("DMA enable does not follow select code");
   a_dma_hi_zero: assert property (cr && CFG_INDEX == IRC_IDX_DMA_SEL |=> CFG_RDATA[7:4] == 4'h0)
      else $error("DMA select upper bits read nonzero");
   a_drq_float: assert property ($onehot0(DMA_REQUEST_OUT_OE) &&
      DMA_REQUEST_OUT_O == (DMA_REQUEST_OUT_OE & {4{ENG_DMA_REQ}}))
      else $error("unselected request line driven");
   a_tmo_cfg: assert property (cw && CFG_INDEX == IRC_IDX_HD_TMO |=> ENG_TMO == $past(CFG_IO.data))
      else $error("engine timeout copy missed config write");
   a_tmo_eng: assert property (ew && !cw |=> ENG_TMO == $past(ENG_WR.data))
      else $error("timeout copy missed engine write");
   a_soft_keep: assert property (ENG_SOFT_RST && !cw && !ENG_WR.wr |=> $stable(ENG_TMO))
      else $error("engine soft reset changed timeout");
   a_sel_a_wire: assert property (cw && CFG_INDEX == IRC_IDX_SW_SEL_A |=> ENG_SW_SEL_A == $past(CFG_IO.data))
      else $error("select A not passed to engine");
   a_rt_window: assert property (RT_SEL |-> IO_ADDR[15:12] == 4'h0 && IO_ADDR[11:8] != 4'h0)
      else $error("runtime decode outside allowed window");
   a_rt_offset: assert property (RT_WAKE_SEL == (RT_SEL && IO_ADDR[4:0] == IRC_RT_OFS_WAKE) &&
      RT_OFFSET == (RT_SEL ? IO_ADDR[4:0] : 5'h00))
      else $error("runtime offset or wake select wrong");
endmodule : irc_cfg_bank_sva
bind irc_cfg_bank irc_cfg_bank_sva irc_cfg_bank_sva_inst (.*);

// ---- sim/irc_host.sv ----
// Host model issuing configuration cycles and I/O addresses
`timescale 1ns/1ns
module irc_host (
   // Clock and read data
   input wire logic clk,
   input wire logic [7:0] rdata,
   // Config cycle and I/O address
   output logic cfg_state,
   output logic [7:0] index,
   output irc_pkg::irc_io_t io,
   output logic [15:0] io_addr
);
   import irc_pkg::*;
   localparam int FLOPPY_DMA = 2;
   initial begin
      cfg_state = 1'b1;
      index = 8'h00;
      io = '0;
      io_addr = 16'h0000;
   end
   task automatic access(input logic st, input logic [7:0] idx, input logic w, input logic [7:0] d);
      @(posedge clk);
      cfg_state <= st;
      index <= idx;
      io <= '{wr: w, rd: !w, addr: 16'h0000, data: d};
      @(posedge clk);
      // Released data is inverted so stale values never look valid
      io <= '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, data: ~d};
      cfg_state <= 1'b1;
   endtask : access
   task automatic point(input logic [15:0] a);
      @(posedge clk);
      io_addr <= a;
   endtask : point
endmodule : irc_host

// ---- sim/tb_irc_cfg_bank.sv ----
// Testbench for the IR config bank
`timescale 1ns/1ns
module tb_irc_cfg_bank;
   import irc_pkg::*;
   localparam int STEP = 4;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic soft_rst = 1'b0;
   logic dma_req = 1'b1;
   logic tmo_start = 1'b0;
   irc_eng_wr_t eng_wr = '0;
   irc_io_t io;
   logic cfg_state, rt_sel, wake, busy, done;
   logic [7:0] index, rdata, tmo, sel_a, sel_b;
   logic [15:0] io_addr;
   logic [4:0] ofs;
   logic [3:0] dma_request_out, oe;
   logic [7:0] rst_exp [5] = '{8'h0F, 8'h03, 8'h00, 8'h00, 8'h00};
   logic [15:0] adr [5] = '{16'h0240, 16'h0257, 16'h1240, 16'h0260, 16'h00E0};
   logic [15:0] rt_exp [5] = '{16'h60, 16'h57, 16'h00, 16'h00, 16'h00};
   int n_mismatch = 0;
   int num_checks = 0;
   int n;
   always #4 clk = ~clk;
   irc_host irc_host_inst (.clk(clk), .rdata(rdata), .cfg_state(cfg_state), .index(index),
      .io(io), .io_addr(io_addr));
   irc_cfg_bank #(.STEP_CYC(STEP)) irc_cfg_bank_inst (.CLK(clk), .NRST(nrst),
      .CFG_STATE(cfg_state), .CFG_INDEX(index), .CFG_IO(io), .CFG_RDATA(rdata),
      .IO_ADDR(io_addr), .RT_SEL(rt_sel), .RT_OFFSET(ofs), .RT_WAKE_SEL(wake),
      .ENG_WR(eng_wr), .ENG_SOFT_RST(soft_rst), .ENG_DMA_REQ(dma_req), .TMO_START(tmo_start),
      .ENG_TMO(tmo), .ENG_SW_SEL_A(sel_a), .ENG_SW_SEL_B(sel_b), .TMO_BUSY(busy),
      .TMO_DONE(done), .DMA_REQUEST_OUT_O(dma_request_out), .DMA_REQUEST_OUT_OE(oe));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         irc_host_inst.access(1'b1, 8'(IRC_IDX_DMA_SEL + i), 1'b0, 8'h00);
         #1 chk(rdata, rst_exp[i]);
      end
      for (int c = 0; c < 16; c++) begin
         irc_host_inst.access(1'b1, IRC_IDX_DMA_SEL, 1'b1, {4'hA, 4'(c)});
         #1 chk(oe, (c < 4) ? 16'h1 << c : 16'h0);
         chk(dma_request_out, (c < 4) ? 16'h1 << c : 16'h0);
         irc_host_inst.access(1'b1, IRC_IDX_DMA_SEL, 1'b0, 8'h00);
         #1 chk(rdata, 16'(c));
      end
      irc_host_inst.access(1'b1, IRC_IDX_HD_TMO, 1'b1, 8'h5A);
      #1 chk(tmo, 8'h5A);
      @(posedge clk) eng_wr <= '{wr: 1'b1, blk: IRC_ENG_BLK_TMO, addr: IRC_ENG_ADR_TMO, data: 8'h02};
      @(posedge clk) eng_wr <= '0;
      soft_rst <= 1'b1;
      @(posedge clk) soft_rst <= 1'b0;
      irc_host_inst.access(1'b1, IRC_IDX_HD_TMO, 1'b0, 8'h00);
      #1 chk(rdata, 8'h02);
      @(posedge clk) tmo_start <= 1'b1;
      @(posedge clk) tmo_start <= 1'b0;
      #1 chk(busy, 1'b1);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (done !== 1'b1 && n < 100);
      chk(16'(n), 16'(2 * STEP));
      chk(busy, 1'b0);
      irc_host_inst.access(1'b1, IRC_IDX_SW_SEL_A, 1'b1, 8'hC3);
      #1 chk(sel_a, 8'hC3);
      irc_host_inst.access(1'b1, IRC_IDX_SW_SEL_B, 1'b1, 8'h3C);
      #1 chk(sel_b, 8'h3C);
      @(posedge clk) eng_wr <= '{wr: 1'b1, blk: IRC_ENG_BLK_SWS, addr: IRC_ENG_ADR_SWS_B, data: 8'h96};
      @(posedge clk) eng_wr <= '0;
      #1 chk(sel_b, 8'h96);
      irc_host_inst.access(1'b0, IRC_IDX_SW_SEL_A, 1'b1, 8'h11);
      irc_host_inst.access(1'b1, 8'h31, 1'b1, 8'h11);
      #1 chk(sel_a, 8'hC3);
      irc_host_inst.access(1'b1, IRC_IDX_RT_BASE, 1'b1, 8'h25);
      irc_host_inst.access(1'b1, IRC_IDX_RT_BASE, 1'b0, 8'h00);
      #1 chk(rdata, 8'h24);
      for (int i = 0; i < 5; i++) begin
         if (i == 4)
            irc_host_inst.access(1'b1, IRC_IDX_RT_BASE, 1'b1, 8'h0E);
         irc_host_inst.point(adr[i]);
         #1 chk({rt_sel, wake, ofs}, rt_exp[i]);
      end
      report_and_stop();
   end
endmodule : tb_irc_cfg_bank

// ---- src/irc_cfg_bank.sv ----
// IR DMA, turnaround timeout, software select and runtime base configuration bank
`timescale 1ns/1ns
// Overview of operation
// RULE_01: Registers answer only in config state with index
// RULE_02: Low nibble picks DMA channel 0-3 or none
// RULE_03: DMA select bits 7:4 read zero
// RULE_04: Unselected DMA request outputs float
// RULE_05: DMA select resets to 0x0F
// RULE_06: Software puts floppy controller on DMA 2
// RULE_07: Timeout equals value times 100 us
// RULE_08: Timeout resets to 0x03
// RULE_09: Both timeout copies update on either write
// RULE_10: Engine soft reset keeps timeout copies
// RULE_11: Select A drives engine block 3 address 5
// RULE_12: Select B drives engine block 3 address 6
// RULE_13: Select A, B, base reset to 0x00
// RULE_14: Base bits 7:1 hold address bits 11:5
// RULE_15: Base below 100h disables runtime decode
// RULE_16: Decode needs A15:12 zero and base match
// RULE_17: A4:0 select register, zero is wake status
// RULE_18: Base bit 0 reads zero
module irc_cfg_bank #(
   parameter int STEP_CYC = irc_pkg::IRC_TMO_STEP_CYC
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Configuration access
   input wire logic CFG_STATE,
   input wire logic [7:0] CFG_INDEX,
   input wire irc_pkg::irc_io_t CFG_IO,
   output logic [7:0] CFG_RDATA,
   // Host I/O address for runtime decode
   input wire logic [15:0] IO_ADDR,
   output logic RT_SEL,
   output logic [4:0] RT_OFFSET,
   output logic RT_WAKE_SEL,
   // Engine side
   input wire irc_pkg::irc_eng_wr_t ENG_WR,
   input wire logic ENG_SOFT_RST,
   input wire logic ENG_DMA_REQ,
   input wire logic TMO_START,
   output logic [7:0] ENG_TMO,
   output logic [7:0] ENG_SW_SEL_A,
   output logic [7:0] ENG_SW_SEL_B,
   output logic TMO_BUSY,
   output logic TMO_DONE,
   // DMA request pins
   output logic [irc_pkg::IRC_DMA_CHANS-1:0] DMA_REQUEST_OUT_O,
   output logic [irc_pkg::IRC_DMA_CHANS-1:0] DMA_REQUEST_OUT_OE
);
   import irc_pkg::*;
   initial begin
      if (IRC_DMA_CHANS != 4) begin
         $error("irc_cfg_bank: four DMA channels expected");
      end
   end
   function automatic logic idx_hit(input logic [7:0] idx, input logic [7:0] want);
      idx_hit = (idx == want);
   endfunction : idx_hit
   function automatic logic eng_hit(input irc_eng_wr_t w, input logic [2:0] b, input logic [2:0] a);
      eng_hit = w.wr && (w.blk == b) && (w.addr == a);
   endfunction : eng_hit
   logic [7:0] dma_sel_reg;
   logic [7:0] dma_sel_next;
   logic [7:0] tmo_reg;
   logic [7:0] tmo_next;
   logic [7:0] sws_a_reg;
   logic [7:0] sws_a_next;
   logic [7:0] sws_b_reg;
   logic [7:0] sws_b_next;
   logic [7:0] rt_base_reg;
   logic [7:0] rt_base_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   // RULE_01 Config state gating
   wire cfg_wr = CFG_STATE && CFG_IO.wr;
   wire cfg_rd = CFG_STATE && CFG_IO.rd;
   wire hit_dma = idx_hit(CFG_INDEX, IRC_IDX_DMA_SEL);
   wire hit_tmo = idx_hit(CFG_INDEX, IRC_IDX_HD_TMO);
   wire hit_swa = idx_hit(CFG_INDEX, IRC_IDX_SW_SEL_A);
   wire hit_swb = idx_hit(CFG_INDEX, IRC_IDX_SW_SEL_B);
   wire hit_rtb = idx_hit(CFG_INDEX, IRC_IDX_RT_BASE);
   // RULE_03 Upper nibble masked
   assign dma_sel_next = (cfg_wr && hit_dma) ? (CFG_IO.data & IRC_DMA_SEL_MASK) : dma_sel_reg;
   // RULE_09 Either write updates the shared copy
   wire eng_tmo_wr = eng_hit(ENG_WR, IRC_ENG_BLK_TMO, IRC_ENG_ADR_TMO);
   // RULE_10 Engine soft reset is not a term here
   assign tmo_next = (cfg_wr && hit_tmo) ? CFG_IO.data : (eng_tmo_wr ? ENG_WR.data : tmo_reg);
   // RULE_11 Select A writable from either side
   wire eng_swa_wr = eng_hit(ENG_WR, IRC_ENG_BLK_SWS, IRC_ENG_ADR_SWS_A);
   assign sws_a_next = (cfg_wr && hit_swa) ? CFG_IO.data : (eng_swa_wr ? ENG_WR.data : sws_a_reg);
   // RULE_12 Select B writable from either side
   wire eng_swb_wr = eng_hit(ENG_WR, IRC_ENG_BLK_SWS, IRC_ENG_ADR_SWS_B);
   assign sws_b_next = (cfg_wr && hit_swb) ? CFG_IO.data : (eng_swb_wr ? ENG_WR.data : sws_b_reg);
   // RULE_18 Bit 0 never stored
   assign rt_base_next = (cfg_wr && hit_rtb) ? (CFG_IO.data & IRC_RT_BASE_MASK) : rt_base_reg;
   // RULE_01 Readback only for matching index
   assign rdata_next = !cfg_rd ? rdata_reg :
                       hit_dma ? dma_sel_reg :
                       hit_tmo ? tmo_reg :
                       hit_swa ? sws_a_reg :
                       hit_swb ? sws_b_reg :
                       hit_rtb ? rt_base_reg : 8'h00;
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         // RULE_05 No channel at reset
         dma_sel_reg <= IRC_RST_DMA_SEL;
         // RULE_08 300 us default
         tmo_reg <= IRC_RST_HD_TMO;
         // RULE_13 Cleared defaults
         sws_a_reg <= IRC_RST_SW_SEL;
         sws_b_reg <= IRC_RST_SW_SEL;
         rt_base_reg <= IRC_RST_RT_BASE;
         rdata_reg <= 8'h00;
      end else begin
         dma_sel_reg <= dma_sel_next;
         tmo_reg <= tmo_next;
         sws_a_reg <= sws_a_next;
         sws_b_reg <= sws_b_next;
         rt_base_reg <= rt_base_next;
         rdata_reg <= rdata_next;
      end
   end
   assign CFG_RDATA = rdata_reg;
   // RULE_09 One storage serves both copies so they cannot drift
   assign ENG_TMO = tmo_reg;
   assign ENG_SW_SEL_A = sws_a_reg;
   assign ENG_SW_SEL_B = sws_b_reg;
   // RULE_02 Channel decode; reserved codes select nothing
   wire [3:0] dma_code = dma_sel_reg[3:0];
   wire dma_valid = (dma_code <= IRC_DMA_MAX);
   // RULE_06 Channel 2 is left free for the floppy controller by software
   genvar ch;
   generate
      for (ch = 0; ch < IRC_DMA_CHANS; ch++) begin : g_dma
         // RULE_04 Drive only the chosen channel
         assign DMA_REQUEST_OUT_OE[ch] = dma_valid && (dma_code == 4'(ch));
         assign DMA_REQUEST_OUT_O[ch] = DMA_REQUEST_OUT_OE[ch] && ENG_DMA_REQ;
      end
   endgenerate
   // RULE_14 Base bits map to address 11:5
   wire [6:0] base_addr_bit = rt_base_reg[7:1];
   // RULE_15 Upper base nibble zero disables
   wire rt_enabled = (base_addr_bit[6:3] != IRC_RT_HI_ZERO);
   // RULE_16 Full address match
   assign RT_SEL = rt_enabled && (IO_ADDR[15:12] == 4'h0) && (IO_ADDR[11:5] == base_addr_bit);
   // RULE_17 Offset within block
   assign RT_OFFSET = RT_SEL ? IO_ADDR[4:0] : 5'h00;
   assign RT_WAKE_SEL = RT_SEL && (IO_ADDR[4:0] == IRC_RT_OFS_WAKE);
   // RULE_07 Turnaround timer uses the shared value
   irc_tmo_timer #(
      .STEP_CYC(STEP_CYC)
   ) u_tmo (
      .clk(CLK),
      .nrst(NRST),
      .start(TMO_START),
      .tmo_val(tmo_reg),
      .busy(TMO_BUSY),
      .done(TMO_DONE)
   );
endmodule : irc_cfg_bank

// ---- src/irc_pkg.sv ----
// Package with register map, reset values, field layout and timing for the IR config bank
package irc_pkg;
   localparam logic [7:0] IRC_IDX_DMA_SEL = 8'h2C;
   localparam logic [7:0] IRC_IDX_HD_TMO = 8'h2D;
   localparam logic [7:0] IRC_IDX_SW_SEL_A = 8'h2E;
   localparam logic [7:0] IRC_IDX_SW_SEL_B = 8'h2F;
   localparam logic [7:0] IRC_IDX_RT_BASE = 8'h30;
   localparam logic [7:0] IRC_RST_DMA_SEL = 8'h0F;
   localparam logic [7:0] IRC_RST_HD_TMO = 8'h03;
   localparam logic [7:0] IRC_RST_SW_SEL = 8'h00;
   localparam logic [7:0] IRC_RST_RT_BASE = 8'h00;
   localparam logic [3:0] IRC_DMA_NONE = 4'hF;
   localparam logic [3:0] IRC_DMA_MAX = 4'h3;
   localparam logic [7:0] IRC_DMA_SEL_MASK = 8'h0F;
   localparam logic [7:0] IRC_RT_BASE_MASK = 8'hFE;
   localparam logic [3:0] IRC_RT_HI_ZERO = 4'h0;
   localparam logic [4:0] IRC_RT_OFS_WAKE = 5'h00;
   localparam logic [2:0] IRC_ENG_BLK_TMO = 3'h5;
   localparam logic [2:0] IRC_ENG_ADR_TMO = 3'h1;
   localparam logic [2:0] IRC_ENG_BLK_SWS = 3'h3;
   localparam logic [2:0] IRC_ENG_ADR_SWS_A = 3'h5;
   localparam logic [2:0] IRC_ENG_ADR_SWS_B = 3'h6;
   localparam int IRC_CLK_MHZ = 125;
   localparam int IRC_TMO_STEP_US = 100;
   localparam int IRC_TMO_STEP_CYC = IRC_TMO_STEP_US * IRC_CLK_MHZ;
   localparam int IRC_DMA_CHANS = 4;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] data;
   } irc_io_t;
   typedef struct packed {
      logic wr;
      logic [2:0] blk;
      logic [2:0] addr;
      logic [7:0] data;
   } irc_eng_wr_t;
endpackage : irc_pkg

// ---- src/irc_tmo_timer.sv ----
// Turnaround timer counting register value times the 100 us step
`timescale 1ns/1ns
module irc_tmo_timer #(
   parameter int STEP_CYC = irc_pkg::IRC_TMO_STEP_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   input wire logic start,
   input wire logic [7:0] tmo_val,
   // Status
   output logic busy,
   output logic done
);
   import irc_pkg::*;
   initial begin
      if (STEP_CYC < 1 || STEP_CYC > 65535) begin
         $error("irc_tmo_timer: STEP_CYC out of range");
      end
   end
   logic [15:0] step_reg;
   logic [15:0] step_next;
   logic [7:0] units_reg;
   logic [7:0] units_next;
   logic busy_reg;
   logic busy_next;
   logic done_reg;
   logic done_next;
   wire step_end = (step_reg == 16'(STEP_CYC - 1));
   wire last_unit = (units_reg == 8'h01);
   // Zero value gives an immediate done with no wait
   assign busy_next = start ? (tmo_val != 8'h00) : (busy_reg && !(step_end && last_unit));
   assign done_next = start ? (tmo_val == 8'h00) : (busy_reg && step_end && last_unit);
   assign step_next = (start || !busy_reg || step_end) ? 16'h0000 : step_reg + 16'h0001;
   assign units_next = start ? tmo_val : ((busy_reg && step_end) ? units_reg - 8'h01 : units_reg);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         step_reg <= 16'h0000;
         units_reg <= 8'h00;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         step_reg <= step_next;
         units_reg <= units_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
      end
   end
   assign busy = busy_reg;
   assign done = done_reg;
endmodule : irc_tmo_timer
